//--- core/sss_pkg.sv
// Purpose: shared constants for the synchronous sram select/sleep control block
// Assumes: 40 MHz single clock, 18-bit data, small internal array
// Notes:   widths fixed; array depth kept small for an on-chip model
package sss_pkg;
  localparam int unsigned DATA_W     = 18;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DEPTH      = 16;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned BURST_W    = 2;
  localparam logic        ORDER_LINEAR = 1'b0;
  localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
  localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
  // synchroniser reset: selects read as deselected, clock gate as stalled
  localparam logic [7:0]         PIN_RST   = 8'h0e;
  typedef enum logic [1:0] {
    SSS_IDLE,
    SSS_ACTIVE,
    SSS_SLEEP
  } sss_state_t;
endpackage

//--- core/sss_fifo.sv
// Purpose: small valid/ready fifo in the write data path
// Assumes: single clock, asynchronous active-low reset
// Notes:   full and empty come from an occupancy count
`timescale 1ns/10ps
`default_nettype none
module sss_fifo #(
  parameter int unsigned WIDTH = 18,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready_out  = (cnt_q != (PW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];
  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_q[wr_q] <= in_data_in;
  end
endmodule
`default_nettype wire

//--- core/sss_ctrl.sv
// Purpose: chip-select decode, burst order, clock-gate stall and sleep control of a sync sram
// Assumes: all pins sampled through two flops on clk_in; controller honours its own duties
// Notes:   write data passes a 4-word fifo that drains into the array only on live edges
// Function
// - the device is selected only when select a is low, select b is high and select c is low.
// - burst addresses advance linearly when the order strap is 0 and interleaved when it is 1.
// - an edge with the clock gate inactive is a stall cycle in which nothing is written.
// - after sleep the data lines stay undriven until a later read drives them.
`timescale 1ns/10ps
`default_nettype none
module sss_ctrl
  import sss_pkg::*;
(
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       chip_select_a_n_in,
  input  wire logic                       chip_select_b_in,
  input  wire logic                       chip_select_c_n_in,
  input  wire logic                       clock_gate_n_in,
  input  wire logic                       sleep_request_in,
  input  wire logic                       burst_order_in,
  input  wire logic                       write_n_in,
  input  wire logic                       advance_in,
  input  wire logic [sss_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [sss_pkg::DATA_W-1:0] dq_in,
  output logic      [sss_pkg::DATA_W-1:0] dq_out,
  output logic                            dq_oe_out,
  output logic                            sleeping_out,
  output logic                            wr_ready_out
);
  import sss_pkg::*;

  // two-flop synchronisers; stage one feeds only stage two
  logic [7:0] s1_q;
  logic [7:0] s2_q;
  logic [ADDR_W-1:0] a1_q;
  logic [ADDR_W-1:0] a2_q;
  logic [DATA_W-1:0] d1_q;
  logic [DATA_W-1:0] d2_q;

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      s1_q <= PIN_RST;
      s2_q <= PIN_RST;
      a1_q <= '0;
      a2_q <= '0;
      d1_q <= DATA_RST;
      d2_q <= DATA_RST;
    end
    else
    begin
      s1_q <= {advance_in, write_n_in, burst_order_in, sleep_request_in, clock_gate_n_in,
               chip_select_c_n_in, chip_select_b_in, chip_select_a_n_in};
      s2_q <= s1_q;
      a1_q <= addr_in;
      a2_q <= a1_q;
      d1_q <= dq_in;
      d2_q <= d1_q;
    end
  end

  logic cs_a_n;
  logic cs_b;
  logic cs_c_n;
  logic gate_n;
  logic sleep_req;
  logic order;
  logic wr_n;
  logic adv;
  assign cs_a_n    = s2_q[0];
  assign cs_b      = s2_q[1];
  assign cs_c_n    = s2_q[2];
  assign gate_n    = s2_q[3];
  assign sleep_req = s2_q[4];
  assign order     = s2_q[5];
  assign wr_n      = s2_q[6];
  assign adv       = s2_q[7];

  logic selected;
  logic live;
  assign selected = !cs_a_n && cs_b && !cs_c_n;
  assign live     = !gate_n;

  sss_state_t        state_q;
  logic [ADDR_W-1:0] base_q;
  logic [BURST_W-1:0] cnt_q;
  logic [ADDR_W-1:0] cur_addr;
  logic [BURST_W-1:0] offs;
  logic              start_acc;
  logic              adv_acc;
  logic              rd_acc;
  logic              wr_acc;
  logic              is_wr_q;
  logic [ADDR_W-1:0] acc_base;
  logic [BURST_W-1:0] acc_cnt;

  // a starting access uses the address taken on this edge, not the held base
  assign acc_base = start_acc ? a2_q : base_q;
  // an advance uses the next count, so a burst of up to 4 words never repeats its first word
  assign acc_cnt  = start_acc ? BURST_RST : cnt_q + 2'h1;
  // interleaved order flips low address bits instead of adding, so the burst wraps in place
  assign offs = (order == ORDER_LINEAR) ? acc_base[BURST_W-1:0] + acc_cnt
                                        : acc_base[BURST_W-1:0] ^ acc_cnt;
  assign cur_addr = {acc_base[ADDR_W-1:BURST_W], offs};

  // a new access needs a live edge, an awake part and a full select
  assign start_acc = live && (state_q != SSS_SLEEP) && selected && !adv;
  // an advance continues only an active burst, and only on a live edge
  assign adv_acc   = live && (state_q == SSS_ACTIVE) && adv;
  assign rd_acc    = (start_acc && wr_n) || (adv_acc && !is_wr_q);
  assign wr_acc    = (start_acc && !wr_n) || (adv_acc && is_wr_q);

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q <= SSS_IDLE;
      base_q  <= '0;
      cnt_q   <= BURST_RST;
      is_wr_q <= 1'b0;
    end
    else if (sleep_req)
      // relies on the controller having deselected first
      state_q <= SSS_SLEEP;
    else if (live)
    begin
      if (start_acc)
      begin
        state_q <= SSS_ACTIVE;
        base_q  <= a2_q;
        cnt_q   <= BURST_RST;
        is_wr_q <= !wr_n;
      end
      else if (adv_acc)
        cnt_q <= cnt_q + 1'b1;
      else if (state_q == SSS_SLEEP || !selected)
        state_q <= SSS_IDLE;
    end
  end

  // write data queue; array writes happen only on live edges
  logic              fifo_out_valid;
  logic [DATA_W-1:0] fifo_out_data;
  logic              fifo_in_ready;
  logic [ADDR_W-1:0] wa_q [FIFO_DEPTH];
  logic [1:0]        wa_wr_q;
  logic [1:0]        wa_rd_q;
  logic              drain;
  logic              push;
  assign push  = wr_acc && fifo_in_ready;
  assign drain = live && fifo_out_valid;

  sss_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (wr_acc),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (d2_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (drain),
    .out_data_out  (fifo_out_data)
  );

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wa_wr_q <= '0;
      wa_rd_q <= '0;
    end
    else
    begin
      if (push)
        wa_wr_q <= wa_wr_q + 1'b1;
      if (drain)
        wa_rd_q <= wa_rd_q + 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (push)
      wa_q[wa_wr_q] <= cur_addr;
  end

  logic [DATA_W-1:0] array_q [DEPTH];
  always_ff @(posedge clk_in)
  begin
    if (drain)
      array_q[wa_q[wa_rd_q]] <= fifo_out_data;
  end

  // outputs: registered; a stall edge holds dq_out and dq_oe_out unless sleep clears the drive
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dq_out       <= DATA_RST;
      dq_oe_out    <= 1'b0;
      sleeping_out <= 1'b0;
      wr_ready_out <= 1'b0;
    end
    else
    begin
      sleeping_out <= sleep_req;
      wr_ready_out <= fifo_in_ready;
      if (sleep_req || state_q == SSS_SLEEP)
        dq_oe_out <= 1'b0;
      else if (live)
      begin
        dq_oe_out <= rd_acc;
        if (rd_acc)
          dq_out <= array_q[cur_addr];
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/sss_props.sv
// Purpose: port checker for sss_ctrl
// Assumes: a pin takes effect 3 edges after it is sampled
// Notes: one clock domain, so default clocking
`timescale 1ns/10ps
`default_nettype none
module sss_props
  import sss_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic chip_select_a_n_in,
  input wire logic chip_select_b_in,
  input wire logic chip_select_c_n_in,
  input wire logic clock_gate_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_in,
  input wire logic write_n_in,
  input wire logic advance_in,
  input wire logic [sss_pkg::ADDR_W-1:0] addr_in,
  input wire logic [sss_pkg::DATA_W-1:0] dq_in,
  input wire logic [sss_pkg::DATA_W-1:0] dq_out,
  input wire logic dq_oe_out,
  input wire logic sleeping_out,
  input wire logic wr_ready_out
);
  wire logic sel = !chip_select_a_n_in && chip_select_b_in && !chip_select_c_n_in;
  wire logic live = !clock_gate_n_in && !sleep_request_in;
  wire logic newop = sel && live && !advance_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  AST_READ_DRIVES: assert property ($past(newop && write_n_in, 3) |-> dq_oe_out)
    else $error("read not driven");
  AST_WRITE_HIGHZ: assert property ($past(newop && !write_n_in, 3) |-> !dq_oe_out)
    else $error("dq driven on write");
  AST_DESEL_HIGHZ: assert property ($past(!sel && live && !advance_in, 3) |-> !dq_oe_out)
    else $error("dq driven while deselected");
  AST_READ_CAUSE: assert property ($rose(dq_oe_out) |->
    $past(live && (sel && write_n_in || advance_in), 3))
    else $error("drive without read");
  AST_STALL_HOLD: assert property ($past(clock_gate_n_in && !sleep_request_in, 3) |->
    $stable(dq_out) && $stable(dq_oe_out))
    else $error("stall edge changed outputs");
  AST_SLEEP_QUIET: assert property (sleeping_out |=> !dq_oe_out)
    else $error("dq driven in sleep");
  AST_WAKE_HIGHZ: assert property ($fell(sleeping_out) |-> !dq_oe_out)
    else $error("dq driven on wake");
  cover property ($rose(dq_oe_out));
  cover property ($rose(sleeping_out));
  cover property ($past(clock_gate_n_in, 3) && dq_oe_out);
endmodule
bind sss_ctrl sss_props sss_props_inst (.*);
`default_nettype wire

//--- dv/sss_host.sv
// Purpose: memory controller model driving the sram pins
// Assumes: one request per task call, pins change after a rising edge
// Notes: a released data line shows the inverse of its last word, so a second read in a row restores that word
`timescale 1ns/10ps
`default_nettype none
module sss_host
  import sss_pkg::*;
(
  input wire logic clk_in,
  output logic chip_select_a_n_out,
  output logic chip_select_b_out,
  output logic chip_select_c_n_out,
  output logic clock_gate_n_out,
  output logic sleep_request_out,
  output logic write_n_out,
  output logic advance_out,
  output logic [sss_pkg::ADDR_W-1:0] addr_out,
  output logic [sss_pkg::DATA_W-1:0] dq_out
);
  initial
  begin
    {chip_select_a_n_out, chip_select_b_out, chip_select_c_n_out} = 3'h4;
    {clock_gate_n_out, sleep_request_out, write_n_out, advance_out} = 4'h2;
    addr_out = '0;
    dq_out = '0;
  end
  // single accesses or bursts, caller's choice
  task cyc(input logic [2:0] cs, input logic gn, wn, adv,
           input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    {chip_select_a_n_out, chip_select_b_out, chip_select_c_n_out} <= cs;
    clock_gate_n_out <= gn;
    write_n_out <= wn;
    advance_out <= adv;
    addr_out <= a;
    dq_out <= wn ? ~dq_out : d;
  endtask
  // deselect first, then change the sleep level
  task nap(input logic z);
    cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
    @(posedge clk_in);
    sleep_request_out <= z;
  endtask
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Purpose: self-checking bench for sss_ctrl, its write queue included
// Assumes: 40 MHz clock, reset low for 20 cycles
// Notes: reads are judged in the one cycle the answer stands
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sss_pkg::*;
  logic clk_in, rst_b_in, a_n, b, c_n, gn, zz, wn, adv, ord, oe, slp, wrdy;
  logic [DATA_W-1:0] hd, rd;
  logic [ADDR_W-1:0] addr;
  wire logic [DATA_W-1:0] dq_wire = oe ? rd : hd;
  int failures, samples_checked;
  sss_ctrl sss_ctrl_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .chip_select_a_n_in(a_n),
    .chip_select_b_in(b), .chip_select_c_n_in(c_n), .clock_gate_n_in(gn),
    .sleep_request_in(zz), .burst_order_in(ord), .write_n_in(wn), .advance_in(adv),
    .addr_in(addr), .dq_in(dq_wire), .dq_out(rd), .dq_oe_out(oe), .sleeping_out(slp),
    .wr_ready_out(wrdy));
  sss_host sss_host_inst (.clk_in(clk_in), .chip_select_a_n_out(a_n), .chip_select_b_out(b),
    .chip_select_c_n_out(c_n), .clock_gate_n_out(gn), .sleep_request_out(zz),
    .write_n_out(wn), .advance_out(adv), .addr_out(addr), .dq_out(hd));
  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task conclude;
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [DATA_W:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    sss_host_inst.cyc(3'h2, 1'b0, 1'b1, 1'b0, a, '0);
    sss_host_inst.cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
    repeat (2) @(posedge clk_in);
    #1 chk({oe, rd}, {1'b1, e});
  endtask
  task t_rw_desel_stall;
    sss_host_inst.cyc(3'h2, 1'b0, 1'b0, 1'b0, 4'h9, 18'h2a5c3);
    for (int i = 0; i < 8; i++)
      if (i != 2)
        sss_host_inst.cyc(3'(i), 1'b0, 1'b0, 1'b0, 4'h9, 18'h3ffff);
    sss_host_inst.cyc(3'h2, 1'b1, 1'b0, 1'b0, 4'h9, 18'h00001);
    sss_host_inst.cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
    rdchk(4'h9, 18'h2a5c3);
    // a read must keep its answer through stall edges
    sss_host_inst.cyc(3'h2, 1'b0, 1'b1, 1'b0, 4'h9, '0);
    repeat (4) sss_host_inst.cyc(3'h4, 1'b1, 1'b1, 1'b0, '0, '0);
    #1 chk({oe, rd}, {1'b1, 18'h2a5c3});
  endtask
  task t_burst;
    for (int o = 0; o < 2; o++)
    begin
      @(posedge clk_in);
      ord <= 1'(o);
      sss_host_inst.cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
      repeat (3) @(posedge clk_in);
      for (int k = 0; k < 4; k++)
        sss_host_inst.cyc(3'h2, 1'b0, 1'b0, 1'(k != 0), 4'h5, 18'(16 * o + k));
      sss_host_inst.cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
      for (int k = 0; k < 4; k++)
        rdchk({2'h1, o ? (2'h1 ^ 2'(k)) : 2'(1 + k)}, 18'(16 * o + k));
    end
  endtask
  task t_sleep;
    sss_host_inst.cyc(3'h2, 1'b0, 1'b1, 1'b0, 4'h9, '0);
    sss_host_inst.nap(1'b1);
    repeat (6) @(posedge clk_in);
    #1 chk({slp, oe}, 2'h2);
    sss_host_inst.nap(1'b0);
    repeat (6) @(posedge clk_in);
    #1 chk({slp, oe}, 2'h0);
    rdchk(4'h9, 18'h2a5c3);
  endtask
  // back-to-back single writes pass the write queue and land at their own addresses
  task t_fifo;
    for (int i = 0; i < 4; i++)
    begin
      sss_host_inst.cyc(3'h2, 1'b0, 1'b0, 1'b0, 4'(i), 18'(18'h10000 + i));
      #1 chk(wrdy, 1'b1);
    end
    sss_host_inst.cyc(3'h4, 1'b0, 1'b1, 1'b0, '0, '0);
    for (int i = 0; i < 4; i++)
      rdchk(4'(i), 18'(18'h10000 + i));
  endtask
  initial
  begin
    {rst_b_in, ord} = 2'h0;
    repeat (19) @(posedge clk_in);
    #1 chk({oe, slp, wrdy}, 3'h0);
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    #1 chk(wrdy, 1'b1);
    t_rw_desel_stall;
    t_burst;
    t_sleep;
    t_fifo;
    conclude;
  end
  // the run needs some 135 cycles, so 4000 only trips on a hang
  initial
  begin
    #(25 * 4000);
    failures++;
    conclude;
  end
endmodule
`default_nettype wire
